// file: pkg/acs_defs.vh
`ifndef ACS_DEFS_VH
`define ACS_DEFS_VH

// clock and timing
`define ACS_CLK_PERIOD_NS   5
`define ACS_SETTLE_NS       50000
`define ACS_SETTLE_CYCLES   ((`ACS_SETTLE_NS + `ACS_CLK_PERIOD_NS - 1) / `ACS_CLK_PERIOD_NS)
// modulator sample strobe divider, arbitrary default
`define ACS_SAMPLE_DIV      5

// serial exchange edge numbers
`define ACS_APPLY_EDGE      6'h0d
`define ACS_START_EDGE      6'h20
`define ACS_EDGE_MAX        6'h3f

// configuration word, shifted msb first on rising edges
`define ACS_CFG_BITS        4'hc
`define ACS_CFG_POS_HI      11
`define ACS_CFG_POS_LO      10
`define ACS_CFG_NEG_HI      9
`define ACS_CFG_NEG_LO      8
`define ACS_CFG_OSR_HI      7
`define ACS_CFG_OSR_LO      4
`define ACS_CFG_TWOX        3

// oversample ratio, 64 shifted left by the code, code 9 gives 32768
`define ACS_OSR_MIN         16'h0040
`define ACS_OSR_CODE_MAX    4'h9

// result and readout
`define ACS_RESULT_W        24
`define ACS_WORD_W          32
`define ACS_FIFO_DEPTH      8
`define ACS_FIFO_AW         3

`endif

// file: rtl/acs_fifo.v
`default_nettype none

module acs_fifo #(
    parameter WIDTH = 24,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    // clock and reset
    input  wire             clk,
    input  wire             rst_b,
    // fill side
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    // drain side
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0]      wr_ptr_q;
    reg [AW:0]      rd_ptr_q;
    reg [AW:0]      count_q;

    wire push = in_valid & in_ready;
    wire pop  = out_valid & out_ready;

    localparam [AW:0] DEPTH_V = DEPTH;
    localparam [AW:0] LAST_V  = DEPTH - 1;

    assign in_ready  = (count_q != DEPTH_V);
    assign out_valid = (count_q != {(AW+1){1'b0}});
    assign out_data  = mem[rd_ptr_q[AW-1:0]];

    always @(posedge clk)
    begin
        if (push)
            mem[wr_ptr_q[AW-1:0]] <= in_data;
    end

    always @(posedge clk)
    begin
        if (!rst_b)
        begin
            wr_ptr_q <= {(AW+1){1'b0}};
            rd_ptr_q <= {(AW+1){1'b0}};
            count_q  <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
                wr_ptr_q <= (wr_ptr_q == LAST_V) ? {(AW+1){1'b0}} : wr_ptr_q + 1'b1;
            if (pop)
                rd_ptr_q <= (rd_ptr_q == LAST_V) ? {(AW+1){1'b0}} : rd_ptr_q + 1'b1;
            if (push & ~pop)
                count_q <= count_q + 1'b1;
            else if (pop & ~push)
                count_q <= count_q - 1'b1;
        end
    end

endmodule

`default_nettype wire

// file: rtl/acs_sequencer.v
`include "acs_defs.vh"
`default_nettype none

// Functional notes
// - two opposite-polarity halves cancel offset
// - 13th falling edge routes new channel pair
// - conversion starts at 32nd falling edge
// - midpoint swaps channels between amplifiers
// - second half subtracted from first
// - end of conversion restores same-channel polarity
// - different channel switches again at edge 13
// - double speed reverses after first half
// - double speed waits 50us before second half
module acs_sequencer #(
    parameter SETTLE_CYCLES = `ACS_SETTLE_CYCLES,
    parameter SAMPLE_DIV    = `ACS_SAMPLE_DIV,
    parameter RESULT_W      = `ACS_RESULT_W,
    parameter FIFO_DEPTH    = `ACS_FIFO_DEPTH,
    parameter FIFO_AW       = `ACS_FIFO_AW
) (
    // clock and reset
    input  wire       REF_CLK,
    input  wire       RST_B,
    // serial link
    input  wire       SCK,
    input  wire       CS_B,
    input  wire       SDI,
    output reg        SDO,
    // modulator bitstream
    input  wire       MOD_BIT,
    // multiplexer control
    output reg  [1:0] AMP_A_POSITIVE_INPUT,
    output reg  [1:0] AMP_B_POSITIVE_INPUT,
    output reg        AMP_SWAPPED,
    // status
    output reg        BUSY
);

    localparam [4:0] ST_IDLE   = 5'h01;
    localparam [4:0] ST_HALF1  = 5'h02;
    localparam [4:0] ST_SETTLE = 5'h04;
    localparam [4:0] ST_HALF2  = 5'h08;
    localparam [4:0] ST_STORE  = 5'h10;

    localparam [15:0] SETTLE_LAST = SETTLE_CYCLES - 1;
    localparam [7:0]  DIV_LAST    = SAMPLE_DIV - 1;

    // synchronised pins, chip select idles high
    wire [3:0] sync_v;
    wire       s_sck = sync_v[0];
    wire       s_cs_b = sync_v[1];
    wire       s_sdi = sync_v[2];
    wire       s_mod = sync_v[3];

    acs_sync #(
        .WIDTH     (4),
        .RESET_VAL (2)
    ) u_sync (
        .clk      (REF_CLK),
        .rst_b    (RST_B),
        .async_in ({MOD_BIT, SDI, CS_B, SCK}),
        .sync_out (sync_v)
    );

    reg                 sck_prev_q;
    reg                 cs_prev_q;
    reg  [5:0]          fall_cnt_q;
    reg  [3:0]          rise_cnt_q;
    reg  [11:0]         cfg_sh_q;
    reg  [1:0]          ch_pos_q;
    reg  [1:0]          ch_neg_q;
    reg  [3:0]          osr_code_q;
    reg                 twox_q;
    reg  [4:0]          state_q;
    reg  [15:0]         samp_cnt_q;
    reg  [15:0]         settle_cnt_q;
    reg  [7:0]          div_cnt_q;
    reg                 strobe_q;
    reg  [RESULT_W-1:0] acc_q;
    reg  [`ACS_WORD_W-1:0] out_sh_q;

    wire active   = ~s_cs_b;
    wire sck_rise = active & s_sck & ~sck_prev_q;
    wire sck_fall = active & ~s_sck & sck_prev_q;
    wire cs_fall  = ~s_cs_b & cs_prev_q;
    wire [5:0] fall_next = fall_cnt_q + 6'h01;
    wire apply_edge = sck_fall & (fall_next == `ACS_APPLY_EDGE);
    wire start_edge = sck_fall & (fall_next == `ACS_START_EDGE);
    wire idle = state_q[0];

    // oversample ratio from the latched code, clamped at the top code
    wire [3:0]  code_c   = (osr_code_q > `ACS_OSR_CODE_MAX) ? `ACS_OSR_CODE_MAX : osr_code_q;
    wire [15:0] osr_c    = `ACS_OSR_MIN << code_c;
    // double speed runs each half at half length to raise the output rate
    wire [15:0] half_len = twox_q ? {1'b0, osr_c[15:1]} : osr_c;
    wire        half_end = strobe_q & (samp_cnt_q == half_len - 16'h0001);

    // fifo between the filter and the readout
    wire                fifo_in_ready;
    wire                fifo_out_valid;
    wire [RESULT_W-1:0] fifo_out_data;

    acs_fifo #(
        .WIDTH (RESULT_W),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_fifo (
        .clk       (REF_CLK),
        .rst_b     (RST_B),
        .in_valid  (state_q[4]),
        .in_ready  (fifo_in_ready),
        .in_data   (acc_q),
        .out_valid (fifo_out_valid),
        .out_ready (cs_fall),
        .out_data  (fifo_out_data)
    );

    // edge detection and configuration shifting
    always @(posedge REF_CLK)
    begin
        if (!RST_B)
        begin
            sck_prev_q <= 1'b0;
            cs_prev_q  <= 1'b1;
            fall_cnt_q <= 6'h00;
            rise_cnt_q <= 4'h0;
            cfg_sh_q   <= 12'h000;
            ch_pos_q   <= 2'h0;
            ch_neg_q   <= 2'h1;
            osr_code_q <= 4'h0;
            twox_q     <= 1'b0;
        end
        else
        begin
            sck_prev_q <= s_sck;
            cs_prev_q  <= s_cs_b;
            if (!active)
            begin
                fall_cnt_q <= 6'h00;
                rise_cnt_q <= 4'h0;
            end
            else
            begin
                if (sck_fall && fall_cnt_q != `ACS_EDGE_MAX)
                    fall_cnt_q <= fall_next;
                if (sck_rise && rise_cnt_q < `ACS_CFG_BITS)
                begin
                    cfg_sh_q   <= {cfg_sh_q[10:0], s_sdi};
                    rise_cnt_q <= rise_cnt_q + 4'h1;
                end
            end
            // a new word is only taken while no conversion runs
            if (apply_edge && idle)
            begin
                ch_pos_q   <= cfg_sh_q[`ACS_CFG_POS_HI:`ACS_CFG_POS_LO];
                ch_neg_q   <= cfg_sh_q[`ACS_CFG_NEG_HI:`ACS_CFG_NEG_LO];
                osr_code_q <= cfg_sh_q[`ACS_CFG_OSR_HI:`ACS_CFG_OSR_LO];
                twox_q     <= cfg_sh_q[`ACS_CFG_TWOX];
            end
        end
    end

    // modulator sample strobe
    always @(posedge REF_CLK)
    begin
        if (!RST_B)
        begin
            div_cnt_q <= 8'h00;
            strobe_q  <= 1'b0;
        end
        else
        begin
            strobe_q  <= (div_cnt_q == DIV_LAST);
            div_cnt_q <= (div_cnt_q == DIV_LAST) ? 8'h00 : div_cnt_q + 8'h01;
        end
    end

    // conversion sequencer
    always @(posedge REF_CLK)
    begin
        if (!RST_B)
        begin
            state_q      <= ST_IDLE;
            samp_cnt_q   <= 16'h0000;
            settle_cnt_q <= 16'h0000;
            acc_q        <= {RESULT_W{1'b0}};
            BUSY         <= 1'b0;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    if (start_edge)
                    begin
                        state_q    <= ST_HALF1;
                        samp_cnt_q <= 16'h0000;
                        acc_q      <= {RESULT_W{1'b0}};
                        BUSY       <= 1'b1;
                    end
                end
                ST_HALF1:
                begin
                    if (strobe_q)
                    begin
                        acc_q      <= s_mod ? acc_q + 1'b1 : acc_q - 1'b1;
                        samp_cnt_q <= samp_cnt_q + 16'h0001;
                    end
                    if (half_end)
                    begin
                        samp_cnt_q   <= 16'h0000;
                        settle_cnt_q <= 16'h0000;
                        state_q      <= twox_q ? ST_SETTLE : ST_HALF2;
                    end
                end
                ST_SETTLE:
                begin
                    // amplifiers slew to the swapped inputs here
                    settle_cnt_q <= settle_cnt_q + 16'h0001;
                    if (settle_cnt_q == SETTLE_LAST)
                        state_q <= ST_HALF2;
                end
                ST_HALF2:
                begin
                    if (strobe_q)
                    begin
                        // swapped inputs, so subtracting doubles signal and cancels offset
                        acc_q      <= s_mod ? acc_q - 1'b1 : acc_q + 1'b1;
                        samp_cnt_q <= samp_cnt_q + 16'h0001;
                    end
                    if (half_end)
                        state_q <= ST_STORE;
                end
                ST_STORE:
                begin
                    // a full fifo holds the sequencer here with busy still high
                    if (fifo_in_ready)
                    begin
                        state_q <= ST_IDLE;
                        BUSY    <= 1'b0;
                    end
                end
                default:
                begin
                    state_q <= ST_IDLE;
                    BUSY    <= 1'b0;
                end
            endcase
        end
    end

    // multiplexer routing
    always @(posedge REF_CLK)
    begin
        if (!RST_B)
        begin
            AMP_A_POSITIVE_INPUT <= 2'h0;
            AMP_B_POSITIVE_INPUT <= 2'h1;
            AMP_SWAPPED          <= 1'b0;
        end
        else if (apply_edge && idle)
        begin
            // same channel leaves the pins unchanged, a new one switches here
            AMP_A_POSITIVE_INPUT <= cfg_sh_q[`ACS_CFG_POS_HI:`ACS_CFG_POS_LO];
            AMP_B_POSITIVE_INPUT <= cfg_sh_q[`ACS_CFG_NEG_HI:`ACS_CFG_NEG_LO];
            AMP_SWAPPED          <= 1'b0;
        end
        else if (state_q[1] && half_end)
        begin
            AMP_A_POSITIVE_INPUT <= ch_neg_q;
            AMP_B_POSITIVE_INPUT <= ch_pos_q;
            AMP_SWAPPED          <= 1'b1;
        end
        else if (state_q[4] && fifo_in_ready)
        begin
            // gives extra settling when the same channel repeats
            AMP_A_POSITIVE_INPUT <= ch_pos_q;
            AMP_B_POSITIVE_INPUT <= ch_neg_q;
            AMP_SWAPPED          <= 1'b0;
        end
    end

    // readout shifter, word loaded at chip select fall
    always @(posedge REF_CLK)
    begin
        if (!RST_B)
        begin
            out_sh_q <= {`ACS_WORD_W{1'b0}};
            SDO      <= 1'b0;
        end
        else if (cs_fall)
        begin
            out_sh_q <= {fifo_out_valid, {(`ACS_WORD_W-1-RESULT_W){1'b0}},
                         fifo_out_valid ? fifo_out_data : {RESULT_W{1'b0}}};
            SDO      <= fifo_out_valid;
        end
        else if (sck_fall)
        begin
            out_sh_q <= {out_sh_q[`ACS_WORD_W-2:0], 1'b0};
            SDO      <= out_sh_q[`ACS_WORD_W-2];
        end
    end

endmodule

`default_nettype wire

// file: rtl/acs_sync.v
`default_nettype none

module acs_sync #(
    parameter WIDTH     = 1,
    parameter RESET_VAL = 0
) (
    // clock and reset
    input  wire             clk,
    input  wire             rst_b,
    // asynchronous inputs and their synchronised copies
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

    localparam [WIDTH-1:0] RST_V = RESET_VAL;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1)
        begin : g_bit
            reg meta_q;
            reg stable_q;
            always @(posedge clk)
            begin
                if (!rst_b)
                begin
                    meta_q   <= RST_V[i];
                    stable_q <= RST_V[i];
                end
                else
                begin
                    meta_q   <= async_in[i];
                    stable_q <= meta_q;
                end
            end
            assign sync_out[i] = stable_q;
        end
    endgenerate

endmodule

`default_nettype wire

// file: verif/acs_host_model.sv
`default_nettype none
module acs_host_model (
    // clock
    input  wire logic ref_clk,
    // serial link
    output var logic  sck,
    output var logic  cs_b,
    output var logic  sdi,
    input  wire logic sdo
);
    timeunit 1ns;
    timeprecision 1ps;
    int half = 8;
    initial
    begin
        sck = 1'b0;
        cs_b = 1'b1;
        sdi = 1'b0;
    end
    // idle data keeps moving so a stale bit never looks valid
    always @(posedge ref_clk)
        if (cs_b)
            sdi <= ~sdi;
    // sck rests low between frames; data changes after falls, sampled on rises
    task automatic exchange(input logic [11:0] cfg, input int nclk, output logic [31:0] rx);
        logic [31:0] word;
        word = {cfg, 20'h00000};
        rx = 32'h0;
        @(posedge ref_clk);
        cs_b <= 1'b0;
        @(posedge ref_clk);
        sdi <= word[31];
        for (int i = 0; i < nclk; i++)
        begin
            repeat (half) @(posedge ref_clk);
            sck <= 1'b1;
            rx = {rx[30:0], sdo};
            repeat (half) @(posedge ref_clk);
            sck <= 1'b0;
            word = {word[30:0], 1'b0};
            sdi <= word[31];
        end
        repeat (half) @(posedge ref_clk);
        cs_b <= 1'b1;
    endtask
endmodule
`default_nettype wire

// file: verif/acs_seq_asserts.sv
`default_nettype none
module acs_chk #(
    parameter int SETTLE_CYCLES = 20
) (
    // clock and reset
    input wire logic       REF_CLK,
    input wire logic       RST_B,
    // serial link
    input wire logic       SCK,
    input wire logic       CS_B,
    input wire logic       SDI,
    // multiplexer and status
    input wire logic [1:0] AMP_A_POSITIVE_INPUT,
    input wire logic [1:0] AMP_B_POSITIVE_INPUT,
    input wire logic       AMP_SWAPPED,
    input wire logic       BUSY
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RST_B);
    wire  [1:0]  pa = AMP_A_POSITIVE_INPUT;
    wire  [1:0]  pb = AMP_B_POSITIVE_INPUT;
    logic        sck_q;
    logic [5:0]  fall_q;
    logic [11:0] cfg_q;
    logic        twox_q;
    logic [3:0]  pair_q;
    int          swp_q = 0;
    // pin edges are seen here a few cycles before the design's synchronisers
    wire         fall = sck_q & ~SCK & ~CS_B;
    always @(posedge REF_CLK)
    begin
        sck_q <= SCK;
        fall_q <= CS_B ? 6'h00 : fall_q + {5'h00, fall};
        if (!sck_q && SCK && !CS_B && fall_q < 6'h0c)
            cfg_q <= {cfg_q[10:0], SDI};
        if (fall && fall_q == 6'h0c && !BUSY)
            twox_q <= cfg_q[3];
        if (!BUSY)
            pair_q <= {pa, pb};
        swp_q <= AMP_SWAPPED ? swp_q + 1 : 0;
    end
    sequence s_edge13;
        fall && fall_q == 6'h0c && !BUSY;
    endsequence
    sequence s_edge32;
        fall && fall_q == 6'h1f && !BUSY;
    endsequence
    AST_APPLY: assert property (
        s_edge13 |-> ##[2:6] ({pa, pb} == cfg_q[11:8] && !AMP_SWAPPED))
        else $error("pair not applied after edge 13");
    AST_START: assert property (s_edge32 |-> ##[2:6] $rose(BUSY))
        else $error("no start after edge 32");
    AST_CAUSE: assert property ($rose(BUSY) |-> fall_q == 6'h20 && !CS_B)
        else $error("start without edge 32");
    AST_SWAP: assert property (
        $rose(AMP_SWAPPED) |-> BUSY && {pa, pb} == {$past(pb), $past(pa)})
        else $error("swap did not exchange amplifiers");
    AST_HOLD: assert property (AMP_SWAPPED |-> BUSY)
        else $error("reversed outside a conversion");
    AST_RESTORE: assert property (
        $fell(BUSY) |-> {pa, pb} == pair_q && !AMP_SWAPPED)
        else $error("polarity not restored at end");
    AST_SETTLE: assert property (
        $fell(AMP_SWAPPED) && twox_q |-> swp_q >= SETTLE_CYCLES)
        else $error("settling wait too short");
    AST_MUX_CAUSE: assert property (
        $changed(pa) || $changed(pb) |-> $changed(AMP_SWAPPED) || fall_q == 6'h0d)
        else $error("multiplexer moved without cause");
endmodule
bind acs_sequencer acs_chk #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_chk (
    .REF_CLK(REF_CLK), .RST_B(RST_B), .SCK(SCK), .CS_B(CS_B), .SDI(SDI),
    .AMP_A_POSITIVE_INPUT(AMP_A_POSITIVE_INPUT), .AMP_B_POSITIVE_INPUT(AMP_B_POSITIVE_INPUT),
    .AMP_SWAPPED(AMP_SWAPPED), .BUSY(BUSY));
`default_nettype wire

// file: verif/acs_sequencer_tb.sv
`default_nettype none
module acs_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        mod_bit = 1'b0;
    logic        follow = 1'b1;
    logic        fixed_bit = 1'b0;
    logic [31:0] rx;
    wire         sck, cs_b, sdi, sdo, swapped, busy;
    wire  [1:0]  amp_a, amp_b;
    int          bad_count = 0;
    int          tests_run = 0;

    always #2.5 ref_clk = ~ref_clk;
    // a real input follows the polarity, a pure offset does not
    always @(posedge ref_clk)
        mod_bit <= follow ? ~swapped : fixed_bit;

    acs_sequencer #(.SETTLE_CYCLES(20), .SAMPLE_DIV(8)) dut (
        .REF_CLK(ref_clk), .RST_B(rst_b), .SCK(sck), .CS_B(cs_b), .SDI(sdi), .SDO(sdo),
        .MOD_BIT(mod_bit), .AMP_A_POSITIVE_INPUT(amp_a), .AMP_B_POSITIVE_INPUT(amp_b),
        .AMP_SWAPPED(swapped), .BUSY(busy));
    acs_host_model host (.ref_clk(ref_clk), .sck(sck), .cs_b(cs_b), .sdi(sdi), .sdo(sdo));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // one full exchange; the word read back belongs to the previous conversion
    task automatic conv(input logic [11:0] cfg, input logic [31:0] exp_rx);
        int n;
        host.exchange(cfg, 32, rx);
        chk(rx, exp_rx);
        chk({28'h0, amp_a, amp_b}, {28'h0, cfg[11:8]});
        chk({31'h0, busy}, 32'h1);
        n = 0;
        while (busy !== 1'b0 && n < 20000)
        begin
            @(posedge ref_clk);
            n++;
        end
        chk({27'h0, amp_a, amp_b, swapped}, {27'h0, cfg[11:8], 1'b0});
    endtask

    task automatic t_autozero;
        conv(12'hb00, 32'h00000000);
        follow <= 1'b0;
        fixed_bit <= 1'b1;
        conv(12'hb00, 32'h80000080);
        $display("autozero done");
    endtask

    task automatic t_double;
        follow <= 1'b1;
        conv(12'h408, 32'h80000000);
        host.half = 12;
        conv(12'h110, 32'h80000040);
        host.half = 8;
        $display("double speed done");
    endtask

    task automatic t_short;
        host.exchange(12'he00, 24, rx);
        chk({8'h0, rx[23:0]}, 32'h00800001);
        chk({28'h0, amp_a, amp_b}, 32'h0000000e);
        repeat (16) @(posedge ref_clk);
        chk({31'h0, busy}, 32'h0);
        conv(12'he00, 32'h00000000);
        $display("short exchange done");
    endtask

    // the fifo is reached through the readout: one queued word, then empty
    task automatic t_fifo;
        host.exchange(12'h000, 8, rx);
        chk({24'h0, rx[7:0]}, 32'h00000080);
        chk({31'h0, busy}, 32'h0);
        host.exchange(12'h000, 8, rx);
        chk({24'h0, rx[7:0]}, 32'h00000000);
        chk({28'h0, amp_a, amp_b}, 32'h0000000e);
        $display("fifo done");
    endtask

    initial
    begin
        repeat (4) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge ref_clk);
        chk({25'h0, amp_a, amp_b, swapped, busy, sdo}, 32'h00000008);
        t_autozero();
        t_double();
        t_short();
        t_fifo();
        end_of_test();
    end

    initial
    begin
        repeat (60000) @(posedge ref_clk);
        bad_count++;
        $display("[ERR] %0t watchdog expired", $time);
        end_of_test();
    end
endmodule
`default_nettype wire
